// >>> design/rfgr_cmd_core.v
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "rfgr_regs.vh"

// Operation
// R1: Gain codes 20h..2Fh give 17..47 dB, 2 dB a step.
// R2: Host tries gains 29h,2A,28,2B,27,2C,26, then default.
// R3: Host steps gain around default when retries fail.
// R4: Host re-optimises gain on card change.
// R5: Reset command taken any time; abandons transfers. The code ignores it while collecting argument bytes.
// R6: Host resets only on trouble, well after last sequence.
// R7: Reset command leaves the safety lockout set.
// R8: Code 0A on clean chip answer or local command.
// R9: Code CA on card link error.
// R10: No card (detect high) returns 3Ah, no card traffic.
// R11: Identification returns the 4-byte chip identifier.
// R12: Read returns 128 bytes, masked bytes zero.
// R13: Decrement returns the decreased counter byte.
// R14: Gain setup with carrier off returns 6A.
// R15: Setup with carrier off gives 6A; wake starts carrier, retry. Here only gain setup gives 6A; carrier-off and antenna setup give 0A.
// R16: Host sends gain after reset before card commands.
// R17: Host homes, steps, writes; after failure reads and repeats.
// R18: Host may reissue a read after retry.
// R19: Setup upper byte 00 sets gain from lower byte.
// R20: Setup upper byte 80 stops the carrier.
// R21: Carrier stops about 40 seconds after it starts.
// R22: One response per command before the next.
// R23: Gain held until gain setup or reset.
module rfgr_cmd_core #(
    parameter [31:0] SAFETY_CYCLES = `RFGR_SAFETY_TIME_S * `RFGR_CLK_HZ
) (
    input  wire        mclk, // 40 MHz clock
    input  wire        arst_n, // Async reset
    input  wire [3:0]  reg_addr, // Word index
    input  wire [31:0] reg_wdata, // Write data
    input  wire        reg_wr, // Write strobe
    input  wire        reg_rd, // Read strobe
    output reg  [31:0] reg_rdata, // Read data
    input  wire [7:0]  rx_data, // Host byte
    input  wire        rx_valid, // Host byte strobe
    output reg  [7:0]  tx_data, // Response byte
    output reg         tx_valid, // Response valid
    input  wire        tx_ready, // Sender takes byte
    input  wire        detect_n, // Card present, low
    output reg         card_start, // Transfer start
    output reg  [7:0]  card_op, // Transfer opcode
    output reg  [31:0] card_arg, // Transfer arguments
    output reg         card_abort, // Transfer abandon
    input  wire        card_done, // Transfer end
    input  wire        card_err, // Transfer error
    input  wire [7:0]  card_rx_byte, // Card byte
    input  wire        card_rx_valid, // Card byte strobe
    output reg         carrier_on, // Carrier enable
    output reg  [2:0]  antenna_sel, // Antenna 1..4
    output reg  [3:0]  gain_sel, // Gain step
    output wire        lockout // Safety lockout
);

    localparam [3:0] S_IDLE = 4'b0001;
    localparam [3:0] S_ARGS = 4'b0010;
    localparam [3:0] S_CARD = 4'b0100;
    localparam [3:0] S_SEND = 4'b1000;

    reg  [3:0]  state;
    reg  [7:0]  cmd_op;
    reg  [31:0] args;
    reg  [2:0]  arg_cnt;
    reg  [7:0]  gain_code;
    reg  [31:0] mask;
    reg  [7:0]  last_code;
    reg  [7:0]  stat_code;
    reg         resp_stat;
    reg         resp_read;
    reg  [7:0]  resp_len;
    reg  [7:0]  resp_idx;
    reg  [6:0]  card_cnt;
    reg  [7:0]  resp_mem [0:127];
    reg         det_s1;
    reg         det_s2;
    wire        expire;
    wire        no_card;
    wire        reset_cmd;
    wire [7:0]  send_byte;

    // Number of argument bytes that follow each opcode
    function [2:0] arg_len;
        input [7:0] op;
        begin
            case (op)
                `RFGR_OP_SETUP:    arg_len = 3'd2;
                `RFGR_OP_PTR_STEP: arg_len = 3'd4;
                `RFGR_OP_PTR_HOME: arg_len = 3'd4;
                `RFGR_OP_WRITE:    arg_len = 3'd4;
                `RFGR_OP_SELECT:   arg_len = 3'd4;
                `RFGR_OP_COUNT:    arg_len = 3'd1;
                default:           arg_len = 3'd0;
            endcase
        end
    endfunction

    // Payload length returned for a successful card command
    function [7:0] payload_len;
        input [7:0] op;
        begin
            case (op)
                `RFGR_OP_READ:  payload_len = `RFGR_LEN_READ;
                `RFGR_OP_IDENT: payload_len = `RFGR_LEN_IDENT;
                `RFGR_OP_COUNT: payload_len = `RFGR_LEN_VALUE;
                default:        payload_len = 8'd0;
            endcase
        end
    endfunction

    rfgr_safety_timer #(
        .SAFETY_CYCLES (SAFETY_CYCLES)
    ) u_safety (
        .mclk       (mclk),
        .arst_n     (arst_n),
        .carrier_on (carrier_on),
        .expire     (expire),
        .lockout    (lockout)
    );

    always @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            det_s1 <= 1'b1;
            det_s2 <= 1'b1;
        end
        else
        begin
            det_s1 <= detect_n;
            det_s2 <= det_s1;
        end
    end

    assign no_card   = det_s2;
    // Reset opcode outside argument collection interrupts everything
    assign reset_cmd = rx_valid && (rx_data == `RFGR_OP_RESET) && (state != S_ARGS); // R5
    assign send_byte = resp_stat ? stat_code :
                       (resp_read && mask[resp_idx[6:2]]) ? 8'h00 : // R12
                       resp_mem[resp_idx[6:0]];

    always @(posedge mclk)
    begin
        if ((state == S_CARD) && card_rx_valid)
            resp_mem[card_cnt] <= card_rx_byte; // R11
    end

    task queue_status;
        input [7:0] code;
        begin
            stat_code <= code;
            last_code <= code;
            resp_stat <= 1'b1;
            resp_read <= 1'b0;
            resp_len  <= `RFGR_LEN_STATUS;
            resp_idx  <= 8'd0;
            state     <= S_SEND; // R22
        end
    endtask

    task run_command;
        input [7:0]  op;
        input [31:0] prm;
        begin
            if (op == `RFGR_OP_SETUP)
            begin
                if (prm[15:8] == `RFGR_PRM_CARRIER_OFF)
                begin
                    carrier_on <= 1'b0; // R20
                    queue_status(`RFGR_RSP_OK);
                end
                else if (prm[15:8] == `RFGR_PRM_GAIN && !carrier_on)
                    queue_status(`RFGR_RSP_NOT); // R14 R15
                else if (prm[15:8] == `RFGR_PRM_GAIN)
                begin
                    if (prm[7:0] >= `RFGR_GAIN_MIN && prm[7:0] <= `RFGR_GAIN_MAX)
                        gain_code <= prm[7:0]; // R19 R23
                    queue_status(`RFGR_RSP_OK); // R8
                end
                else
                begin
                    if (prm[15:8] == `RFGR_PRM_ANTENNA &&
                        prm[7:0] >= `RFGR_ANT_MIN && prm[7:0] <= `RFGR_ANT_MAX)
                        antenna_sel <= prm[2:0];
                    queue_status(`RFGR_RSP_OK);
                end
            end
            else if (no_card)
                queue_status(`RFGR_RSP_NO_CARD); // R10
            else if (lockout)
                queue_status(`RFGR_RSP_RETRY); // R7
            else if (!carrier_on)
            begin
                if (op == `RFGR_OP_WAKE)
                    carrier_on <= 1'b1; // R15
                queue_status(`RFGR_RSP_RETRY);
            end
            else
            begin
                card_op    <= op;
                card_arg   <= prm;
                card_start <= 1'b1;
                card_cnt   <= 7'd0;
                state      <= S_CARD;
            end
        end
    endtask

    always @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state       <= S_IDLE;
            cmd_op      <= 8'h00;
            args        <= 32'h0000_0000;
            arg_cnt     <= 3'd0;
            gain_code   <= `RFGR_GAIN_DEFAULT;
            antenna_sel <= `RFGR_ANT_DEFAULT;
            carrier_on  <= 1'b0;
            stat_code   <= 8'h00;
            last_code   <= 8'h00;
            resp_stat   <= 1'b1;
            resp_read   <= 1'b0;
            resp_len    <= 8'd0;
            resp_idx    <= 8'd0;
            card_cnt    <= 7'd0;
            card_start  <= 1'b0;
            card_abort  <= 1'b0;
            card_op     <= 8'h00;
            card_arg    <= 32'h0000_0000;
            tx_data     <= 8'h00;
            tx_valid    <= 1'b0;
        end
        else
        begin
            card_start <= 1'b0;
            card_abort <= 1'b0;
            if (reset_cmd)
            begin
                card_abort <= (state == S_CARD); // R5
                tx_valid   <= 1'b0;
                carrier_on <= 1'b0;
                gain_code  <= `RFGR_GAIN_DEFAULT; // R23
                queue_status(`RFGR_RSP_OK);
            end
            else
            begin
                if (expire)
                    carrier_on <= 1'b0; // R21
                case (state)
                    S_IDLE:
                    begin
                        if (rx_valid)
                        begin
                            cmd_op  <= rx_data;
                            args    <= 32'h0000_0000;
                            arg_cnt <= arg_len(rx_data);
                            if (arg_len(rx_data) == 3'd0)
                                run_command(rx_data, 32'h0000_0000);
                            else
                                state <= S_ARGS;
                        end
                    end
                    S_ARGS:
                    begin
                        if (rx_valid)
                        begin
                            args    <= {args[23:0], rx_data};
                            arg_cnt <= arg_cnt - 3'd1;
                            if (arg_cnt == 3'd1)
                                run_command(cmd_op, {args[23:0], rx_data});
                        end
                    end
                    S_CARD:
                    begin
                        if (card_rx_valid)
                            card_cnt <= card_cnt + 7'd1;
                        if (card_done && card_err)
                            queue_status(`RFGR_RSP_RETRY); // R9
                        else if (card_done && payload_len(card_op) == 8'd0)
                            queue_status(`RFGR_RSP_OK); // R8
                        else if (card_done)
                        begin
                            resp_stat <= 1'b0;
                            resp_read <= (card_op == `RFGR_OP_READ); // R12
                            resp_len  <= payload_len(card_op); // R11 R13
                            resp_idx  <= 8'd0;
                            state     <= S_SEND;
                        end
                    end
                    S_SEND:
                    begin
                        if (tx_valid && tx_ready)
                        begin
                            tx_valid <= 1'b0;
                            if (resp_idx == resp_len - 8'd1)
                                state <= S_IDLE; // R22
                            else
                                resp_idx <= resp_idx + 8'd1;
                        end
                        else if (!tx_valid)
                        begin
                            tx_data  <= send_byte;
                            tx_valid <= 1'b1;
                        end
                    end
                    default:
                        state <= S_IDLE;
                endcase
            end
        end
    end

    always @*
    begin
        gain_sel = gain_code[3:0]; // R1
    end

    always @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            mask <= `RFGR_MASK_RESET;
        else if (reg_wr && reg_addr == `RFGR_REG_MASK)
            mask <= reg_wdata;
    end

    always @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            reg_rdata <= 32'h0000_0000;
        else if (reg_rd)
        begin
            reg_rdata <= 32'h0000_0000;
            case (reg_addr)
                `RFGR_REG_STATUS:
                begin
                    reg_rdata[`RFGR_ST_GAIN_HI:`RFGR_ST_GAIN_LO] <= gain_code;
                    reg_rdata[`RFGR_ST_CARRIER] <= carrier_on;
                    reg_rdata[`RFGR_ST_LOCKOUT] <= lockout;
                    reg_rdata[`RFGR_ST_PRESENT] <= ~no_card;
                    reg_rdata[`RFGR_ST_BUSY]    <= (state != S_IDLE);
                    reg_rdata[`RFGR_ST_ANT_HI:`RFGR_ST_ANT_LO] <= antenna_sel;
                end
                `RFGR_REG_MASK: reg_rdata <= mask;
                `RFGR_REG_LAST: reg_rdata <= {24'h000000, last_code};
                default:        reg_rdata <= 32'h0000_0000;
            endcase
        end
        else
            reg_rdata <= 32'h0000_0000;
    end

endmodule // rfgr_cmd_core

// >>> design/rfgr_regs.vh
`ifndef RFGR_REGS_VH
`define RFGR_REGS_VH

// Timing
`define RFGR_CLK_HZ 40000000
`define RFGR_SAFETY_TIME_S 40

// Register map
`define RFGR_ADDR_W 4
`define RFGR_REG_STATUS 4'h0
`define RFGR_REG_MASK 4'h1
`define RFGR_REG_LAST 4'h2

// Status fields and mask reset value
`define RFGR_ST_GAIN_HI 7
`define RFGR_ST_GAIN_LO 0
`define RFGR_ST_CARRIER 8
`define RFGR_ST_LOCKOUT 9
`define RFGR_ST_PRESENT 10
`define RFGR_ST_BUSY 11
`define RFGR_ST_ANT_HI 14
`define RFGR_ST_ANT_LO 12
`define RFGR_MASK_RESET 32'h0000_0000

// Opcodes
`define RFGR_OP_SETUP 8'h5e
`define RFGR_OP_RESET 8'h7e
`define RFGR_OP_PTR_STEP 8'h8e
`define RFGR_OP_PTR_HOME 8'hee
`define RFGR_OP_HALT 8'hae
`define RFGR_OP_COUNT 8'h6e
`define RFGR_OP_WAKE 8'h26
`define RFGR_OP_SELECT 8'h93
`define RFGR_OP_READ 8'h30
`define RFGR_OP_WRITE 8'ha2
`define RFGR_OP_IDENT 8'h60

// Setup parameters
`define RFGR_PRM_GAIN 8'h00
`define RFGR_PRM_CARRIER_OFF 8'h80
`define RFGR_PRM_ANTENNA 8'hf0
`define RFGR_GAIN_MIN 8'h20
`define RFGR_GAIN_MAX 8'h2f
`define RFGR_GAIN_DEFAULT 8'h29
`define RFGR_ANT_MIN 8'h01
`define RFGR_ANT_MAX 8'h04
`define RFGR_ANT_DEFAULT 3'h1

// Response codes
`define RFGR_RSP_OK 8'h0a
`define RFGR_RSP_RETRY 8'hca
`define RFGR_RSP_NO_CARD 8'h3a
`define RFGR_RSP_NOT 8'h6a

// Payload lengths
`define RFGR_LEN_READ 8'd128
`define RFGR_LEN_IDENT 8'd4
`define RFGR_LEN_VALUE 8'd1
`define RFGR_LEN_STATUS 8'd1

`endif

// >>> design/rfgr_safety_timer.v
`timescale 1ns/1ps
`include "rfgr_regs.vh"

module rfgr_safety_timer #(
    parameter [31:0] SAFETY_CYCLES = `RFGR_SAFETY_TIME_S * `RFGR_CLK_HZ
) (
    input  wire mclk,        // System clock
    input  wire arst_n,      // Asynchronous reset, active low
    input  wire carrier_on,  // Carrier currently emitted
    output reg  expire,      // One-cycle pulse at timeout
    output reg  lockout      // Sticky until hardware reset
);

    reg [31:0] count;

    // Restarts at each carrier on
    always @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            count   <= 32'h0000_0000;
            expire  <= 1'b0;
            lockout <= 1'b0;
        end
        else
        begin
            expire <= 1'b0;
            if (!carrier_on)
                count <= 32'h0000_0000;
            else if (count >= SAFETY_CYCLES - 32'h0000_0001)
            begin
                count   <= 32'h0000_0000;
                expire  <= 1'b1; // R21
                lockout <= 1'b1; // R7
            end
            else
                count <= count + 32'h0000_0001;
        end
    end

endmodule // rfgr_safety_timer

// >>> test/rfgr_cmd_core_props.sv
`timescale 1ns/1ps
module rfgr_cmd_core_props #(
    parameter [31:0] SAFETY_CYCLES = 32'd200
) (
    input wire        mclk,        // System clock
    input wire        arst_n,      // Reset, active low
    input wire        reg_rd,      // Read strobe
    input wire [31:0] reg_rdata,   // Read data
    input wire [7:0]  rx_data,     // Host byte
    input wire        rx_valid,    // Host byte strobe
    input wire [7:0]  tx_data,     // Response byte
    input wire        tx_valid,    // Response valid
    input wire        tx_ready,    // Sender takes byte
    input wire        detect_n,    // Card presence, active low
    input wire        card_start,  // Card transfer start
    input wire        card_abort,  // Card transfer abandon
    input wire        carrier_on,  // Carrier enable
    input wire [3:0]  gain_sel,    // Gain step
    input wire        lockout      // Safety lockout
);
    reg  [31:0] on_cnt;
    wire        rst_byte;
    assign rst_byte = rx_valid && (rx_data == 8'h7e);
    // Length of the current unbroken carrier burst
    always @(posedge mclk or negedge arst_n)
        if (!arst_n)
            on_cnt <= 32'h0;
        else
            on_cnt <= carrier_on ? on_cnt + 32'h1 : 32'h0;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    sequence s_stop;
        (rx_valid && rx_data == 8'h5e) ##1 (rx_valid && rx_data == 8'h80) ##1 rx_valid;
    endsequence
    a_lockout_sticky: assert property (lockout |=> lockout)
        else $error("lockout dropped");
    a_lockout_quiet: assert property (lockout |=> !carrier_on)
        else $error("carrier on under lockout");
    a_carrier_limit: assert property (on_cnt <= SAFETY_CYCLES + 32'd2)
        else $error("carrier outlived safety time");
    a_gain_cause: assert property ($changed(gain_sel) |->
        $past(rx_valid) || $past(rx_valid, 2) || $past(rx_valid, 3))
        else $error("gain moved without command");
    a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("response byte not held");
    a_tx_gap: assert property (tx_valid && tx_ready |=> !tx_valid)
        else $error("no gap after taken byte");
    a_no_card: assert property (detect_n [*5] |=> !card_start)
        else $error("card transfer without card");
    a_abort_cause: assert property (card_abort |->
        $past(rst_byte) || $past(rst_byte, 2) || $past(rst_byte, 3))
        else $error("abort without reset command");
    a_stop_ok: assert property (s_stop |-> ##[1:3] (tx_valid && tx_data == 8'h0a && !carrier_on))
        else $error("carrier stop not done");
    a_not_code: assert property ((rx_valid && rx_data == 8'h5e && !carrier_on)
        ##1 (rx_valid && rx_data == 8'h00) ##1 rx_valid
        |-> ##[1:3] (tx_valid && tx_data == 8'h6a))
        else $error("missing carrier-off answer");
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data outside read cycle");
    c_stop: cover property (s_stop);
    c_lock: cover property ($rose(lockout));
    c_abort: cover property (card_abort);
    c_stall: cover property (tx_valid && !tx_ready);
endmodule // rfgr_cmd_core_props

// >>> test/rfgr_far_model.sv
`timescale 1ns/1ps
module rfgr_far_model (
    input  wire       mclk,           // System clock
    input  wire       arst_n,         // Reset, active low
    input  wire       card_start,     // Transfer start
    input  wire [7:0] card_op,        // Transfer opcode
    input  wire       card_abort,     // Transfer abandon
    input  wire       err_mode,       // Finish transfers with error
    input  wire       slow,           // Stall the response sink
    input  wire [7:0] lat,            // Card answer delay
    input  wire [7:0] tx_data,        // Response byte
    input  wire       tx_valid,       // Response valid
    output wire       tx_ready,       // Sink takes byte
    output reg        card_done,      // Transfer end
    output reg        card_err,       // Transfer error
    output reg  [7:0] card_rx_byte,   // Payload byte
    output reg        card_rx_valid,  // Payload strobe
    output integer    n_rsp,          // Response bytes taken
    output integer    n_abort         // Aborts seen
);
    reg     [7:0] rsp [0:1023];
    reg           active;
    reg     [1:0] ph;
    integer       wait_cnt, idx, n_pay;
    assign tx_ready = !slow || (ph == 2'd3);
    always @(posedge mclk or negedge arst_n)
        if (!arst_n)
        begin
            {card_done, card_err, card_rx_valid, active, ph} <= 6'h0;
            card_rx_byte <= 8'h00;
            {n_rsp, n_abort, wait_cnt, idx, n_pay} <= 0;
        end
        else
        begin
            card_done     <= 1'b0;
            card_err      <= 1'b0;
            card_rx_valid <= 1'b0;
            card_rx_byte  <= ~card_rx_byte;
            ph            <= ph + 2'd1;
            if (card_abort)
            begin
                active  <= 1'b0;
                n_abort <= n_abort + 1;
            end
            else if (card_start)
            begin
                active   <= 1'b1;
                wait_cnt <= lat;
                idx      <= 0;
                n_pay    <= card_op == 8'h30 ? 128 : card_op == 8'h60 ? 4 :
                            card_op == 8'h6e ? 1 : 0;
            end
            else if (active && wait_cnt > 0)
                wait_cnt <= wait_cnt - 1;
            else if (active && idx < n_pay)
            begin
                card_rx_valid <= 1'b1;
                card_rx_byte  <= 8'h5a ^ idx[7:0];
                idx           <= idx + 1;
            end
            else if (active)
            begin
                card_done <= 1'b1;
                card_err  <= err_mode;
                active    <= 1'b0;
            end
            if (tx_valid && tx_ready)
            begin
                rsp[n_rsp % 1024] <= tx_data;
                n_rsp             <= n_rsp + 1;
            end
        end
endmodule // rfgr_far_model

// >>> test/rfgr_cmd_core_bench.sv
`timescale 1ns/1ps
module rfgr_cmd_core_bench;
    localparam SC = 6000;
    reg         mclk, arst_n, reg_wr, reg_rd, rx_valid, detect_n, err_mode, slow;
    reg  [3:0]  reg_addr;
    reg  [31:0] reg_wdata, rd;
    reg  [7:0]  rx_data, lat, cur, g;
    wire [31:0] reg_rdata, card_arg;
    wire [7:0]  tx_data, card_op, card_rx_byte;
    wire        tx_valid, tx_ready, card_start, card_abort, card_done, card_err;
    wire        card_rx_valid, carrier_on, lockout;
    wire [2:0]  antenna_sel;
    wire [3:0]  gain_sel;
    integer     n_fail, num_checks, base, k, j;
    rfgr_cmd_core #(.SAFETY_CYCLES(SC)) uut (.mclk(mclk), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .rx_data(rx_data), .rx_valid(rx_valid), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .detect_n(detect_n),
        .card_start(card_start), .card_op(card_op), .card_arg(card_arg),
        .card_abort(card_abort), .card_done(card_done), .card_err(card_err),
        .card_rx_byte(card_rx_byte), .card_rx_valid(card_rx_valid),
        .carrier_on(carrier_on), .antenna_sel(antenna_sel), .gain_sel(gain_sel),
        .lockout(lockout));
    rfgr_far_model far (.mclk(mclk), .arst_n(arst_n), .card_start(card_start),
        .card_op(card_op), .card_abort(card_abort), .err_mode(err_mode), .slow(slow),
        .lat(lat), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .card_done(card_done), .card_err(card_err), .card_rx_byte(card_rx_byte),
        .card_rx_valid(card_rx_valid), .n_rsp(), .n_abort());
    task chk(input [31:0] seen, input [31:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp)
        begin
            n_fail = n_fail + 1;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    function [7:0] rsp_at(input integer i);
        rsp_at = far.rsp[(base + i) % 1024];
    endfunction
    task send(input [39:0] f, input integer n);
        for (k = 0; k < n; k = k + 1)
        begin
            @(posedge mclk);
            rx_valid <= 1'b1;
            rx_data  <= f[8*(n-1-k) +: 8];
        end
        @(posedge mclk);
        rx_valid <= 1'b0;
    endtask
    // Send a frame and wait for the whole answer of length e
    task cmd(input [39:0] f, input integer n, input integer e);
        integer i;
        base = far.n_rsp;
        send(f, n);
        for (i = 0; i < 3000 && far.n_rsp < base + e; i = i + 1)
            @(posedge mclk);
        repeat (10) @(posedge mclk);
        chk(far.n_rsp - base, e);
    endtask
    task reg_rw(input wr, input [3:0] a, input [31:0] d);
        @(posedge mclk);
        reg_wr    <= wr;
        reg_rd    <= !wr;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1 rd = reg_rdata;
    endtask
    task t_startup;
        cmd(40'h5e002a, 3, 1);
        chk(rsp_at(0), 8'h6a);
        chk(gain_sel, 4'h9);
        cmd(40'h26, 1, 1);
        chk(rsp_at(0), 8'hca);
        chk(carrier_on, 1'b1);
    endtask
    task t_gain;
        cur = 8'h29;
        for (j = 0; j < 10; j = j + 1)
        begin
            g = 80'h292a282b272c262f2030 >> (72 - 8 * j);
            if (g >= 8'h20 && g <= 8'h2f)
                cur = g;
            cmd({32'h5e00, g}, 3, 1);
            chk(rsp_at(0), 8'h0a);
            chk(gain_sel, cur[3:0]);
            reg_rw(1'b0, 4'h0, 32'h0);
            chk(rd[7:0], cur);
        end
    endtask
    task t_card;
        reg_rw(1'b1, 4'h1, 32'h1);
        reg_rw(1'b0, 4'h1, 32'h0);
        chk(rd, 32'h1);
        reg_rw(1'b0, 4'h5, 32'h0);
        chk(rd, 32'h0);
        cmd(40'h30, 1, 128);
        for (j = 0; j < 128; j = j + 1)
            chk(rsp_at(j), j < 4 ? 8'h00 : 8'h5a ^ j[7:0]);
        cmd(40'h60, 1, 4);
        for (j = 0; j < 4; j = j + 1)
            chk(rsp_at(j), 8'h5a ^ j[7:0]);
        cmd(40'h6e03, 2, 1);
        chk(rsp_at(0), 8'h5a);
        cmd(40'h9300000001, 5, 1);
        chk({rsp_at(0), card_arg}, {8'h0a, 32'h1});
        cmd(40'hee00000000, 5, 1);
        cmd(40'h8e00000000, 5, 1);
        err_mode <= 1'b1;
        cmd(40'ha2deadbeef, 5, 1);
        chk(rsp_at(0), 8'hca);
        err_mode <= 1'b0;
        cmd(40'h30, 1, 128);
        cmd(40'hee00000000, 5, 1);
        cmd(40'h8e00000000, 5, 1);
        cmd(40'ha2deadbeef, 5, 1);
        chk(rsp_at(0), 8'h0a);
        err_mode <= 1'b1;
        slow     <= 1'b1;
        cmd(40'h30, 1, 1);
        chk(rsp_at(0), 8'hca);
        err_mode <= 1'b0;
        cmd(40'h30, 1, 128);
        chk(rsp_at(4), 8'h5e);
        slow <= 1'b0;
    endtask
    task t_no_card;
        detect_n <= 1'b1;
        repeat (6) @(posedge mclk);
        cmd(40'h30, 1, 1);
        chk(rsp_at(0), 8'h3a);
        detect_n <= 1'b0;
        repeat (6) @(posedge mclk);
        cmd(40'h5e002b, 3, 1);
    endtask
    task t_abort;
        lat <= 8'd80;
        send(40'h30, 1);
        repeat (5) @(posedge mclk);
        cmd(40'h7e, 1, 1);
        repeat (150) @(posedge mclk);
        chk(far.n_rsp - base, 1);
        chk(rsp_at(0), 8'h0a);
        chk(far.n_abort, 1);
        chk(carrier_on, 1'b0);
        chk(gain_sel, 4'h9);
        lat <= 8'd3;
    endtask
    task t_stop;
        cmd(40'h26, 1, 1);
        chk(carrier_on, 1'b1);
        cmd(40'h5e8055, 3, 1);
        chk(rsp_at(0), 8'h0a);
        chk(carrier_on, 1'b0);
        cmd(40'h5ef003, 3, 1);
        chk({rsp_at(0), antenna_sel}, {8'h0a, 3'h3});
    endtask
    task t_lock;
        cmd(40'h26, 1, 1);
        repeat (SC + 20) @(posedge mclk);
        chk(carrier_on, 1'b0);
        chk(lockout, 1'b1);
        cmd(40'h7e, 1, 1);
        chk(lockout, 1'b1);
        cmd(40'h26, 1, 1);
        chk(rsp_at(0), 8'hca);
        chk(carrier_on, 1'b0);
        reg_rw(1'b0, 4'h0, 32'h0);
        chk(rd[9], 1'b1);
        arst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (2) @(posedge mclk);
        chk(lockout, 1'b0);
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    initial
    begin
        #1000000;
        n_fail = n_fail + 1;
        complete_run;
    end
    initial
    begin
        {arst_n, reg_wr, reg_rd, rx_valid, detect_n, err_mode, slow} = 7'h0;
        {reg_addr, reg_wdata, rx_data} = 44'h0;
        lat        = 8'd3;
        n_fail     = 0;
        num_checks = 0;
        repeat (6) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        t_startup;
        t_gain;
        t_card;
        t_no_card;
        t_abort;
        t_stop;
        t_lock;
        complete_run;
    end
endmodule // rfgr_cmd_core_bench
bind rfgr_cmd_core rfgr_cmd_core_props #(.SAFETY_CYCLES(SAFETY_CYCLES)) u_props (
    .mclk(mclk), .arst_n(arst_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_data(rx_data), .rx_valid(rx_valid), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .detect_n(detect_n), .card_start(card_start),
    .card_abort(card_abort), .carrier_on(carrier_on), .gain_sel(gain_sel),
    .lockout(lockout));
